// File: src/clkbuf_params.svh
`ifndef CLKBUF_PARAMS_SVH
`define CLKBUF_PARAMS_SVH

// target address, upper seven bits of the 8'hD6 write address byte
`define TARGET_ADDR7 7'h6B

// register indices
`define REG_COUNT 6
`define REG_RESERVED_ZERO 7'h00
`define REG_ENABLE_LOW_PAIR 7'h01
`define REG_ENABLE_HIGH_PAIR 7'h02
`define REG_REVISION_MAKER 7'h03
`define REG_BYTE_COUNT 7'h04
`define REG_AMPLITUDE 7'h05

// reset values
`define RST_RESERVED_ZERO 8'h00
`define RST_ENABLE_LOW_PAIR 8'h05
`define RST_ENABLE_HIGH_PAIR 8'hC0
`define RST_BYTE_COUNT 8'h06
`define RST_AMPLITUDE 8'hD8

// field positions
`define OUT0_ENABLE_BIT 2
`define OUT1_ENABLE_BIT 0
`define OUT2_ENABLE_BIT 7
`define OUT3_ENABLE_BIT 6
`define SWING_SELECT_BIT 7
`define SWING_CODE_MSB 6
`define SWING_CODE_LSB 4
`define BYTE_MODE_BIT 7
`define REVISION_MSB 7
`define REVISION_LSB 4
`define MAKER_MSB 3
`define MAKER_LSB 0

// output swing in millivolts
`define SWING_BASE_MV 11'h12C
`define SWING_STEP_MV 11'h064
`define SWING_DEFAULT_MV 11'h2BC

`endif

// File: src/clkbuf_pkg.sv
package clkbuf_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_CMD = 4'b0011,
      ST_WDATA = 4'b0100,
      ST_BYTE_ACK = 4'b0101,
      ST_RDATA = 4'b0110,
      ST_HOST_ACK = 4'b0111,
      ST_RNEXT = 4'b1000
   } serial_state_t;

   typedef struct packed {
      logic swing_override_select;
      logic [2:0] swing_level_code;
      logic [10:0] swing_millivolts;
   } swing_t;

   typedef struct packed {
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic scl_prev;
      logic sda_prev;
      serial_state_t state;
      logic [3:0] bits;
      logic [7:0] shift;
      logic [6:0] index;
      logic reading;
      logic block;
      logic count_phase;
      logic [7:0] limit;
      logic [7:0] written;
      logic sda_oe;
      logic [3:0] out_run;
      swing_t swing;
      logic [5:0][7:0] regs;
   } ctrl_state_t;

   typedef struct packed {
      logic rst1;
      logic rst2;
      logic [3:0] en1;
      logic [3:0] en2;
   } ref_state_t;

endpackage : clkbuf_pkg

// File: src/clock_buffer_serial_control.sv
`timescale 1ns/10ps
`include "clkbuf_params.svh"

module clock_buffer_serial_control #(
   parameter logic [3:0] REVISION_NIBBLE = 4'h1, // arbitrary value
   parameter logic [3:0] MAKER_NIBBLE = 4'h5 // arbitrary value
) (
   input wire logic i_mclk, // control clock
   input wire logic i_reset, // synchronous reset, active high
   input wire logic i_ref_clk, // reference_clock_in, clock to fan out
   input wire logic i_serial_bus_clock, // two-wire serial clock from controller
   input wire logic i_serial_bus_data, // two-wire data line level
   output logic o_serial_bus_data, // data line drive value, always low
   output logic o_serial_bus_data_oe, // high while pulling the data line low
   input wire logic i_out0_enable_pin, // output 0 enable pin
   input wire logic i_out1_enable_pin, // output 1 enable pin
   input wire logic i_out2_enable_pin, // output 2 enable pin
   input wire logic i_out3_enable_pin, // output 3 enable pin
   input wire logic i_program_mode, // high while in programming mode
   output logic o_clock_out0, // gated clock output 0
   output logic o_clock_out1, // gated clock output 1
   output logic o_clock_out2, // gated clock output 2
   output logic o_clock_out3, // gated clock output 3
   output clkbuf_pkg::swing_t o_swing // amplitude setting for all outputs
);
   import clkbuf_pkg::*;

   ctrl_state_t q;
   ctrl_state_t d;
   ref_state_t rq;
   ref_state_t rd;
   logic [3:0] gate_q;

   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [3:0] pins;
   logic prog;
   logic [7:0] next_byte;

   function automatic logic [7:0] reg_read(input logic [5:0][7:0] regs,
                                            input logic [6:0] idx);
      logic [7:0] val;
      val = 8'h00;
      if (idx < 7'(`REG_COUNT)) begin
         val = regs[idx[2:0]];
      end
      return val;
   endfunction : reg_read

   function automatic logic write_allowed(input logic [6:0] idx, input logic pm);
      logic ok;
      ok = 1'b0;
      if (idx < 7'(`REG_COUNT)) begin
         ok = 1'b1;
      end
      // enables are the power management settings
      if ((idx == `REG_ENABLE_LOW_PAIR || idx == `REG_ENABLE_HIGH_PAIR) && !pm) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : write_allowed

   always_comb begin
      d = q;
      d.sync1 = {i_program_mode, i_out3_enable_pin, i_out2_enable_pin,
                 i_out1_enable_pin, i_out0_enable_pin, i_serial_bus_data,
                 i_serial_bus_clock};
      d.sync2 = q.sync1;
      scl = q.sync2[0];
      sda = q.sync2[1];
      pins = q.sync2[5:2];
      prog = q.sync2[6];
      d.scl_prev = scl;
      d.sda_prev = sda;
      scl_rise = scl & ~q.scl_prev;
      scl_fall = ~scl & q.scl_prev;
      start_cond = scl & q.scl_prev & q.sda_prev & ~sda;
      stop_cond = scl & q.scl_prev & ~q.sda_prev & sda;

      // byte to send next: count first in a block read
      if (q.count_phase) begin
         next_byte = reg_read(q.regs, `REG_BYTE_COUNT);
      end else begin
         next_byte = reg_read(q.regs, q.index);
      end

      if (start_cond) begin
         // also the repeated start; index and mode survive it
         d.state = ST_ADDR;
         d.bits = 4'h0;
         d.sda_oe = 1'b0;
      end else if (stop_cond) begin
         // early stop after any byte; stored bytes are kept
         d.state = ST_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         case (q.state)
            ST_IDLE: begin
               d.sda_oe = 1'b0;
            end
            ST_ADDR, ST_CMD, ST_WDATA: begin
               if (scl_rise && q.bits != 4'h8) begin
                  d.shift = {q.shift[6:0], sda};
                  d.bits = q.bits + 4'h1;
               end else if (scl_fall && q.bits == 4'h8) begin
                  d.bits = 4'h0;
                  if (q.state == ST_ADDR) begin
                     if (q.shift[7:1] == `TARGET_ADDR7) begin
                        d.reading = q.shift[0];
                        d.sda_oe = 1'b1;
                        d.state = ST_ADDR_ACK;
                     end else begin
                        d.state = ST_IDLE;
                     end
                  end else if (q.state == ST_CMD) begin
                     // bit 7 clear starts a block at index 0
                     d.block = ~q.shift[`BYTE_MODE_BIT];
                     d.count_phase = ~q.shift[`BYTE_MODE_BIT];
                     d.index = q.shift[`BYTE_MODE_BIT] ? q.shift[6:0] : 7'h00;
                     d.written = 8'h00;
                     d.sda_oe = 1'b1;
                     d.state = ST_BYTE_ACK;
                  end else begin
                     if (q.count_phase) begin
                        d.limit = q.shift;
                        d.count_phase = 1'b0;
                     end else begin
                        if ((!q.block || q.written < q.limit) &&
                            write_allowed(q.index, prog)) begin
                           d.regs[q.index[2:0]] = q.shift;
                        end
                        d.index = q.index + 7'h01;
                        d.written = q.written + 8'h01;
                     end
                     d.sda_oe = 1'b1;
                     d.state = ST_BYTE_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (q.reading) begin
                     d.shift = next_byte;
                     d.sda_oe = ~next_byte[7];
                     d.state = ST_RDATA;
                     if (q.count_phase) begin
                        d.count_phase = 1'b0;
                     end else begin
                        d.index = q.index + 7'h01;
                     end
                  end else begin
                     d.sda_oe = 1'b0;
                     d.state = ST_CMD;
                  end
               end
            end
            ST_BYTE_ACK: begin
               if (scl_fall) begin
                  d.sda_oe = 1'b0;
                  d.state = ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  d.bits = q.bits + 4'h1;
               end else if (scl_fall) begin
                  if (q.bits == 4'h8) begin
                     d.bits = 4'h0;
                     d.sda_oe = 1'b0;
                     d.state = ST_HOST_ACK;
                  end else begin
                     d.shift = {q.shift[6:0], 1'b1};
                     d.sda_oe = ~q.shift[6];
                  end
               end
            end
            ST_HOST_ACK: begin
               if (scl_rise) begin
                  // not-acknowledge ends the read; wait for stop
                  d.state = sda ? ST_IDLE : ST_RNEXT;
               end
            end
            ST_RNEXT: begin
               if (scl_fall) begin
                  d.shift = next_byte;
                  d.sda_oe = ~next_byte[7];
                  d.state = ST_RDATA;
                  if (q.count_phase) begin
                     d.count_phase = 1'b0;
                  end else begin
                     d.index = q.index + 7'h01;
                  end
               end
            end
            default: begin
               d.state = ST_IDLE;
               d.sda_oe = 1'b0;
            end
         endcase
      end

      // revision and maker nibbles always present their codes
      d.regs[`REG_REVISION_MAKER][`REVISION_MSB:`REVISION_LSB] = REVISION_NIBBLE;
      d.regs[`REG_REVISION_MAKER][`MAKER_MSB:`MAKER_LSB] = MAKER_NIBBLE;

      // only the enable pins and the function bits steer outputs
      d.out_run[0] = pins[0] & q.regs[`REG_ENABLE_LOW_PAIR][`OUT0_ENABLE_BIT];
      d.out_run[1] = pins[1] & q.regs[`REG_ENABLE_LOW_PAIR][`OUT1_ENABLE_BIT];
      d.out_run[2] = pins[2] & q.regs[`REG_ENABLE_HIGH_PAIR][`OUT2_ENABLE_BIT];
      d.out_run[3] = pins[3] & q.regs[`REG_ENABLE_HIGH_PAIR][`OUT3_ENABLE_BIT];

      d.swing.swing_override_select = q.regs[`REG_AMPLITUDE][`SWING_SELECT_BIT];
      d.swing.swing_level_code = q.regs[`REG_AMPLITUDE][`SWING_CODE_MSB:`SWING_CODE_LSB];
      if (d.swing.swing_override_select) begin
         d.swing.swing_millivolts = `SWING_BASE_MV +
            11'(d.swing.swing_level_code) * `SWING_STEP_MV;
      end else begin
         d.swing.swing_millivolts = `SWING_DEFAULT_MV;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         q <= '0;
         q.sync1 <= 7'h03; // bus idles high so no false start
         q.sync2 <= 7'h03;
         q.scl_prev <= 1'b1;
         q.sda_prev <= 1'b1;
         q.state <= ST_IDLE;
         q.regs[`REG_RESERVED_ZERO] <= `RST_RESERVED_ZERO;
         q.regs[`REG_ENABLE_LOW_PAIR] <= `RST_ENABLE_LOW_PAIR;
         q.regs[`REG_ENABLE_HIGH_PAIR] <= `RST_ENABLE_HIGH_PAIR;
         q.regs[`REG_REVISION_MAKER] <= 8'h00;
         q.regs[`REG_BYTE_COUNT] <= `RST_BYTE_COUNT;
         q.regs[`REG_AMPLITUDE] <= `RST_AMPLITUDE;
      end else begin
         q <= d;
      end
   end

   // reference clock side: reset and enables cross by two flops each
   always_comb begin
      rd = rq;
      rd.rst1 = i_reset;
      rd.rst2 = rq.rst1;
      rd.en1 = q.out_run;
      rd.en2 = rq.en1;
   end

   always_ff @(posedge i_ref_clk) begin
      rq <= rd;
   end

   // gate updates on the falling edge, so only whole high pulses pass
   always_ff @(negedge i_ref_clk) begin
      if (rq.rst2) begin
         gate_q <= 4'h0;
      end else begin
         gate_q <= rq.en2;
      end
   end

   assign o_clock_out0 = i_ref_clk & gate_q[0];
   assign o_clock_out1 = i_ref_clk & gate_q[1];
   assign o_clock_out2 = i_ref_clk & gate_q[2];
   assign o_clock_out3 = i_ref_clk & gate_q[3];
   assign o_serial_bus_data = 1'b0;
   assign o_serial_bus_data_oe = q.sda_oe;
   assign o_swing = q.swing;

endmodule : clock_buffer_serial_control

// File: sim/clock_buffer_serial_control_asserts.sv
`timescale 1ns/10ps
module clock_buffer_serial_control_asserts (
   input wire logic i_mclk, // clock
   input wire logic i_reset, // reset
   input wire logic i_ref_clk, // ref clock
   input wire logic i_serial_bus_clock, // scl
   input wire logic i_serial_bus_data, // sda level
   input wire logic o_serial_bus_data, // sda drive
   input wire logic o_serial_bus_data_oe, // sda enable
   input wire logic i_out0_enable_pin, // pin 0
   input wire logic i_out1_enable_pin, // pin 1
   input wire logic i_out2_enable_pin, // pin 2
   input wire logic i_out3_enable_pin, // pin 3
   input wire logic i_program_mode, // program mode
   input wire logic o_clock_out0, // out 0
   input wire logic o_clock_out1, // out 1
   input wire logic o_clock_out2, // out 2
   input wire logic o_clock_out3, // out 3
   input wire clkbuf_pkg::swing_t o_swing // swing
);
   import clkbuf_pkg::*;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   // counts how long pin 3 has been low, saturating
   logic [3:0] low3_q;
   always_ff @(posedge i_mclk) begin
      if (i_reset || i_out3_enable_pin) low3_q <= 4'h0;
      else if (low3_q != 4'hF) low3_q <= low3_q + 4'h1;
   end
   AST_RESET_DEFAULTS: assert property (
      $fell(i_reset) |=> !o_serial_bus_data_oe && o_swing == {1'h1, 3'h5, 11'h320})
      else $error("state after reset differs from defaults");
   AST_SWING_CODE: assert property (
      o_swing.swing_override_select |->
      o_swing.swing_millivolts == 11'h12C + 11'h064 * o_swing.swing_level_code)
      else $error("swing level does not follow code");
   AST_SWING_DEFAULT: assert property (
      !$past(i_reset) && !o_swing.swing_override_select |->
      o_swing.swing_millivolts == 11'h2BC)
      else $error("default swing wrong");
   AST_DRIVE_LOW: assert property (
      o_serial_bus_data_oe |-> !o_serial_bus_data && !i_serial_bus_data)
      else $error("data line driven other than low");
   AST_SDA_MOVES_SCL_LOW: assert property (
      $changed(o_serial_bus_data_oe) |-> !i_serial_bus_clock)
      else $error("data drive changed while serial clock high");
   AST_OE_RELEASE: assert property (
      $rose(o_serial_bus_data_oe) |-> ##[1:600] !o_serial_bus_data_oe)
      else $error("data line held too long");
   AST_PIN0_STOPS: assert property (
      (!i_out0_enable_pin)[*8] |-> !o_clock_out0)
      else $error("output 0 runs with pin low");
   AST_PIN3_STOPS: assert property (
      low3_q > 4'h9 |-> !o_clock_out3)
      else $error("output 3 runs with pin low");
   AST_WHOLE_PULSES: assert property (
      (o_clock_out0 || o_clock_out1 || o_clock_out2 || o_clock_out3) |-> i_ref_clk)
      else $error("output high outside reference high phase");
endmodule : clock_buffer_serial_control_asserts

bind clock_buffer_serial_control clock_buffer_serial_control_asserts u_asserts (
   .i_mclk(i_mclk), .i_reset(i_reset), .i_ref_clk(i_ref_clk),
   .i_serial_bus_clock(i_serial_bus_clock), .i_serial_bus_data(i_serial_bus_data),
   .o_serial_bus_data(o_serial_bus_data), .o_serial_bus_data_oe(o_serial_bus_data_oe),
   .i_out0_enable_pin(i_out0_enable_pin), .i_out1_enable_pin(i_out1_enable_pin),
   .i_out2_enable_pin(i_out2_enable_pin), .i_out3_enable_pin(i_out3_enable_pin),
   .i_program_mode(i_program_mode), .o_clock_out0(o_clock_out0),
   .o_clock_out1(o_clock_out1), .o_clock_out2(o_clock_out2),
   .o_clock_out3(o_clock_out3), .o_swing(o_swing));

// File: sim/serial_bus_controller.sv
`timescale 1ns/10ps
module serial_bus_controller (
   input wire logic i_mclk, // pacing clock
   input wire logic i_sda, // resolved data line
   output logic o_scl, // serial clock, rests high
   output logic o_sda // data drive, 1 releases
);
   int half = 10;
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic pause();
      repeat (half) @(negedge i_mclk);
   endtask : pause
   // sda moves only well after scl fell, never on the same edge
   task automatic bit_io(input logic b, output logic r);
      repeat (3) @(negedge i_mclk);
      o_sda = b;
      pause();
      o_scl = 1'b1;
      pause();
      r = i_sda;
      o_scl = 1'b0;
   endtask : bit_io
   task automatic start();
      @(negedge i_mclk);
      o_sda = 1'b1;
      pause();
      o_scl = 1'b1;
      pause();
      o_sda = 1'b0;
      pause();
      o_scl = 1'b0;
   endtask : start
   task automatic stop();
      repeat (3) @(negedge i_mclk);
      o_sda = 1'b0;
      pause();
      o_scl = 1'b1;
      pause();
      o_sda = 1'b1;
      pause();
   endtask : stop
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, ack);
   endtask : put_byte
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(last, r);
   endtask : get_byte
endmodule : serial_bus_controller

// File: sim/clock_buffer_serial_control_tb_top.sv
`timescale 1ns/10ps
module clock_buffer_serial_control_tb_top;
   import clkbuf_pkg::*;
   localparam logic [3:0] REV = 4'h3; // arbitrary value
   localparam logic [3:0] MAKER = 4'hA; // arbitrary value
   logic i_mclk, i_reset, i_ref_clk, i_program_mode, scl, ctl_sda, sda_line, dut_sda, dut_oe;
   logic [3:0] pins, outs;
   swing_t swing;
   int failures, checked;
   int edges [4];
   logic [7:0] rst [6] = '{8'h00, 8'h05, 8'hC0, {REV, MAKER}, 8'h06, 8'hD8};
   // pull-up on the shared data line
   assign sda_line = ctl_sda & ~(dut_oe & ~dut_sda);
   clock_buffer_serial_control #(.REVISION_NIBBLE(REV), .MAKER_NIBBLE(MAKER)) dut (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_ref_clk(i_ref_clk),
      .i_serial_bus_clock(scl), .i_serial_bus_data(sda_line),
      .o_serial_bus_data(dut_sda), .o_serial_bus_data_oe(dut_oe),
      .i_out0_enable_pin(pins[0]), .i_out1_enable_pin(pins[1]),
      .i_out2_enable_pin(pins[2]), .i_out3_enable_pin(pins[3]),
      .i_program_mode(i_program_mode), .o_clock_out0(outs[0]), .o_clock_out1(outs[1]),
      .o_clock_out2(outs[2]), .o_clock_out3(outs[3]), .o_swing(swing));
   serial_bus_controller ctl (.i_mclk(i_mclk), .i_sda(sda_line), .o_scl(scl), .o_sda(ctl_sda));
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end
   initial begin
      i_ref_clk = 1'b0;
      #7;
      forever #15 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge outs[0]) edges[0]++;
   always @(posedge outs[1]) edges[1]++;
   always @(posedge outs[2]) edges[2]++;
   always @(posedge outs[3]) edges[3]++;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic put(input logic [7:0] b);
      logic a;
      ctl.put_byte(b, a);
      check({15'h0, a}, 16'h0000);
   endtask : put
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      ctl.start();
      put(8'hD6);
      put(8'h80 | idx);
      put(data);
      ctl.stop();
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] b;
      ctl.start();
      put(8'hD6);
      put(8'h80 | idx);
      ctl.start();
      put(8'hD7);
      ctl.get_byte(1'b1, b);
      ctl.stop();
      check({8'h00, b}, {8'h00, exp});
   endtask : rd
   // disabled outputs must show no rising edge over the window
   task automatic runs(input logic [3:0] exp);
      repeat (20) @(negedge i_mclk);
      edges = '{default: 0};
      repeat (20) @(negedge i_mclk);
      check({12'h0, edges[3] > 0, edges[2] > 0, edges[1] > 0, edges[0] > 0}, {12'h0, exp});
   endtask : runs
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (90000) @(posedge i_mclk);
      failures++;
      conclude();
   end
   initial begin
      logic a;
      logic [7:0] b0, b1, b2;
      i_reset = 1'b1;
      i_program_mode = 1'b1;
      pins = 4'hF;
      repeat (6) @(negedge i_mclk);
      i_reset = 1'b0;
      repeat (4) @(negedge i_mclk);
      check({1'h0, swing}, {1'h0, 1'h1, 3'h5, 11'h320});
      runs(4'hF);
      foreach (rst[i]) rd(8'(i), rst[i]);
      for (int c = 0; c < 8; c++) begin
         wr(8'h05, {1'h1, 3'(c), 4'h0});
         repeat (3) @(negedge i_mclk);
         check({1'h0, swing}, {1'h0, 1'h1, 3'(c), 11'(300 + 100 * c)});
      end
      wr(8'h05, 8'h58);
      repeat (3) @(negedge i_mclk);
      check({1'h0, swing}, {1'h0, 1'h0, 3'h5, 11'h2BC});
      wr(8'h00, 8'hA5);
      rd(8'h00, 8'hA5);
      wr(8'h06, 8'h5A);
      rd(8'h06, 8'h00);
      wr(8'h01, 8'hFA);
      rd(8'h01, 8'hFA);
      runs(4'hC);
      wr(8'h01, 8'h05);
      runs(4'hF);
      i_program_mode = 1'b0;
      wr(8'h02, 8'h00);
      rd(8'h02, 8'hC0);
      runs(4'hF);
      i_program_mode = 1'b1;
      pins = 4'h6;
      runs(4'h6);
      pins = 4'hF;
      ctl.half = 25;
      rd(8'h04, 8'h06);
      ctl.half = 10;
      ctl.start();
      ctl.put_byte(8'hD4, a);
      ctl.stop();
      check({15'h0, a}, 16'h0001);
      ctl.start();
      put(8'hD6);
      put(8'h00);
      put(8'h06);
      put(8'h11);
      put(8'h05);
      put(8'hC0);
      ctl.stop();
      rd(8'h00, 8'h11);
      ctl.start();
      put(8'hD6);
      put(8'h00);
      ctl.start();
      put(8'hD7);
      ctl.get_byte(1'b0, b0);
      ctl.get_byte(1'b0, b1);
      ctl.get_byte(1'b1, b2);
      ctl.stop();
      check({b0, b1}, 16'h0611);
      check({8'h00, b2}, 16'h0005);
      conclude();
   end
endmodule : clock_buffer_serial_control_tb_top
